// ### hdl/epis_ext_irq.sv
// sense, mask and flag logic for two external interrupt pins
//
// What this block does
// - unused register bits always read zero
// - line B vector request needs global enable and mask; wake needs mask only
// - line A vector request needs global enable and mask; wake needs mask only
// - line B sense: low, change, fall, rise
// - line A sense uses same encoding
// - edges detected on sampled pin value
// - pulses over one clock are caught
// - pin as output still raises request
// - mask bit1 line B, bit0 line A
// - each line has own vector request
// - edge sets flag bit1 B, bit0 A
// - set flag plus enables requests vector
// - vector acknowledge clears line flag
// - writing one clears a flag
// - low-level mode holds flag at zero
// - low-level wake asynchronous; low-level vector request and edges need clock
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

`include "epis_cfg.svh"


module epis_ext_irq
	import epis_pkg::*;
#(
	parameter int NUM_LINES = 2
)
(
	// clock and reset
	input  wire logic                 core_clk_in,
	input  wire logic                 srst_in,
	// avalon-mm register slave
	input  wire logic [3:0]           avs_address_in,
	input  wire logic                 avs_read_in,
	input  wire logic                 avs_write_in,
	input  wire logic [31:0]          avs_writedata_in,
	input  wire logic [3:0]           avs_byteenable_in,
	output logic      [31:0]          avs_readdata_out,
	output logic                      avs_waitrequest_out,
	// external pins and core status
	input  wire logic [NUM_LINES-1:0] ext_irq_pin_in,
	input  wire logic                 global_irq_enable_in,
	// vector requests and acknowledges, bit 0 line A, bit 1 line B
	output logic      [NUM_LINES-1:0] vector_req_out,
	input  wire logic [NUM_LINES-1:0] vector_ack_in,
	// asynchronous low-level wake request
	output logic                      wake_req_out,
	// summary interrupt level
	output logic                      irq_out
);

	// register state and next values
	logic [2*NUM_LINES-1:0] sense_r;
	logic [2*NUM_LINES-1:0] sense_nxt;
	logic [NUM_LINES-1:0]   mask_r;
	logic [NUM_LINES-1:0]   mask_nxt;
	logic [NUM_LINES-1:0]   flags_r;
	logic [NUM_LINES-1:0]   flags_nxt;
	logic [NUM_LINES-1:0]   irq_stat_r;
	logic [NUM_LINES-1:0]   irq_stat_nxt;
	logic [NUM_LINES-1:0]   irq_en_r;
	logic [NUM_LINES-1:0]   irq_en_nxt;
	epis_bus_e              bus_r;
	epis_bus_e              bus_nxt;
	logic [31:0]            rdata_r;
	logic [31:0]            rdata_nxt;

	// pin synchroniser and edge history
	logic [NUM_LINES-1:0]   sync1_r;
	logic [NUM_LINES-1:0]   sync2_r;
	logic [NUM_LINES-1:0]   prev_r;

	// decoded bus terms
	logic                   bus_req;
	logic                   wr_take;
	logic                   rd_start;
	logic                   wr_lane0;
	logic [1:0]             widx;
	logic                   sel_sense;
	logic                   sel_mask;
	logic                   sel_flags;
	logic                   sel_stat;

	// per-line terms
	logic [NUM_LINES-1:0]   hit;
	logic [NUM_LINES-1:0]   low_mode;
	logic [NUM_LINES-1:0]   req_raw;
	logic [NUM_LINES-1:0]   flag_clr;
	logic [NUM_LINES-1:0]   stat_clr;
	logic [NUM_LINES-1:0]   wr_low_bits;
	logic [NUM_LINES-1:0]   wr_en_bits;
	logic [2*NUM_LINES-1:0] wr_sense_bits;

	// bus request and write strobe, low byte lane only;
	// a write lands only at the edge that ends the answer cycle
	assign bus_req  = avs_read_in | avs_write_in;
	assign wr_take  = avs_write_in && (bus_r == EPIS_BUS_ACK);
	assign rd_start = avs_read_in && (bus_r == EPIS_BUS_IDLE);
	assign wr_lane0 = wr_take && avs_byteenable_in[0];

	// word decode from byte address bits 3:2
	assign widx      = avs_address_in[3:2];
	assign sel_sense = (widx == `EPIS_IDX_SENSE);
	assign sel_mask  = (widx == `EPIS_IDX_MASK);
	assign sel_flags = (widx == `EPIS_IDX_FLAGS);
	assign sel_stat  = (widx == `EPIS_IDX_IRQ_STAT);

	// write data slices for each register
	assign wr_sense_bits = avs_writedata_in[`EPIS_SENSE_A_LSB +: 2*NUM_LINES];
	assign wr_low_bits   = avs_writedata_in[`EPIS_LINE_A_BIT +: NUM_LINES];
	assign wr_en_bits    = avs_writedata_in[`EPIS_IRQ_EN_LSB +: NUM_LINES];

	// two-flop pin synchroniser, then previous sample for edges;
	// reset loads the idle-high level, so no false edge and no
	// false low-level request follows the release of reset;
	// only the second flop is read by any logic
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			sync1_r <= `EPIS_PIN_IDLE;
			sync2_r <= `EPIS_PIN_IDLE;
			prev_r  <= `EPIS_PIN_IDLE;
		end
		else
		begin
			sync1_r <= ext_irq_pin_in;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// per-line sense decode and edge detection;
	// a pulse must span one full clock to be seen by the sampler
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LINES; gi++)
		begin : g_line
			epis_sense_e sel;
			logic        rise;
			logic        fall;
			// sense field and edge terms of this line
			assign sel  = epis_sense_e'(sense_r[2*gi +: 2]);
			assign rise = ~prev_r[gi] & sync2_r[gi];
			assign fall = prev_r[gi] & ~sync2_r[gi];
			assign low_mode[gi] = (sel == EPIS_SENSE_LOW);
			// edge terms only see the synchronised value
			always_comb
			begin
				case (sel)
					EPIS_SENSE_ANY:  hit[gi] = rise | fall;
					EPIS_SENSE_FALL: hit[gi] = fall;
					EPIS_SENSE_RISE: hit[gi] = rise;
					default:         hit[gi] = 1'b0;
				endcase
			end
			// level mode follows the pin, edge mode follows the flag
			assign req_raw[gi] = low_mode[gi] ? ~sync2_r[gi]
			                                  : flags_r[gi];
		end
	endgenerate

	// write-one-to-clear terms for flags and status;
	// a zero bit in the write leaves its flag alone
	assign flag_clr = (wr_lane0 && sel_flags) ? wr_low_bits : '0;
	assign stat_clr = (wr_lane0 && sel_stat) ? wr_low_bits : '0;

	// sense control next value
	always_comb
	begin
		sense_nxt = sense_r;
		if (wr_lane0 && sel_sense)
		begin
			sense_nxt = wr_sense_bits;
		end
	end

	// sense control register
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			sense_r <= `EPIS_SENSE_RST;
		end
		else
		begin
			sense_r <= sense_nxt;
		end
	end

	// mask next value, bit 1 line B, bit 0 line A
	always_comb
	begin
		mask_nxt = mask_r;
		if (wr_lane0 && sel_mask)
		begin
			mask_nxt = wr_low_bits;
		end
	end

	// mask register
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			mask_r <= `EPIS_MASK_RST;
		end
		else
		begin
			mask_r <= mask_nxt;
		end
	end

	// pending flags: clears first, then a new hit sets again,
	// so an edge in the clearing cycle is never lost;
	// level mode forces the flag to zero
	always_comb
	begin
		flags_nxt = flags_r & ~flag_clr & ~vector_ack_in;
		flags_nxt = (flags_nxt | hit) & ~low_mode;
	end

	// pending flag register
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			flags_r <= `EPIS_FLAGS_RST;
		end
		else
		begin
			flags_r <= flags_nxt;
		end
	end

	// vector requests gated by global enable and mask
	assign vector_req_out = req_raw & mask_r
	                        & {NUM_LINES{global_irq_enable_in}};

	// low-level wake path uses the raw pin, no clock needed;
	// a pin driven as output still counts, its level is read back
	assign wake_req_out = |(low_mode & mask_r & ~ext_irq_pin_in);

	// sticky summary status, set wins over a write-one clear;
	// it records raw requests whether masked or not
	always_comb
	begin
		irq_stat_nxt = (irq_stat_r & ~stat_clr) | req_raw;
	end

	// summary status register
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			irq_stat_r <= '0;
		end
		else
		begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// summary enable next value, shares the status word
	always_comb
	begin
		irq_en_nxt = irq_en_r;
		if (wr_lane0 && sel_stat)
		begin
			irq_en_nxt = wr_en_bits;
		end
	end

	// summary enable register
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			irq_en_r <= '0;
		end
		else
		begin
			irq_en_r <= irq_en_nxt;
		end
	end

	// summary interrupt level
	assign irq_out = |(irq_stat_r & irq_en_r);

	// bus answer sequencer: one wait cycle, one answer cycle,
	// then one rest cycle; a request raised in the rest cycle
	// waits for the sequencer to come round to idle again
	always_comb
	begin
		case (bus_r)
			EPIS_BUS_IDLE: bus_nxt = bus_req ? EPIS_BUS_ACK : EPIS_BUS_IDLE;
			EPIS_BUS_ACK:  bus_nxt = EPIS_BUS_DONE;
			EPIS_BUS_DONE: bus_nxt = EPIS_BUS_IDLE;
			default:       bus_nxt = EPIS_BUS_IDLE;
		endcase
	end

	// bus sequencer state
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			bus_r <= EPIS_BUS_IDLE;
		end
		else
		begin
			bus_r <= bus_nxt;
		end
	end

	// while a request is held, waitrequest low only in the answer cycle
	assign avs_waitrequest_out = bus_req && (bus_r != EPIS_BUS_ACK);

	// read data mux, unused upper bits read as zero;
	// captured in the wait cycle, so it stands in the answer cycle
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (rd_start)
		begin
			case (widx)
				`EPIS_IDX_SENSE:    rdata_nxt = 32'(sense_r);
				`EPIS_IDX_MASK:     rdata_nxt = 32'(mask_r);
				`EPIS_IDX_FLAGS:    rdata_nxt = 32'(flags_r);
				`EPIS_IDX_IRQ_STAT: rdata_nxt = {16'h0000,
				                                 8'(irq_en_r),
				                                 8'(irq_stat_r)};
				default:            rdata_nxt = `EPIS_UNMAPPED_RD;
			endcase
		end
	end

	// read data register, holds until the next read
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			rdata_r <= '0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	// registered read data drives the bus
	assign avs_readdata_out = rdata_r;

endmodule

`default_nettype wire

// ### hdl/epis_cfg.svh
// register offsets, field positions and reset values of the pin interrupt block
`ifndef EPIS_CFG_SVH
`define EPIS_CFG_SVH

// byte addresses on the register bus (word aligned)
`define EPIS_OFS_SENSE      4'h0
`define EPIS_OFS_MASK       4'h4
`define EPIS_OFS_FLAGS      4'h8
`define EPIS_OFS_IRQ_STAT   4'hC

// word index of each register (byte address bits 3:2)
`define EPIS_IDX_SENSE      2'h0
`define EPIS_IDX_MASK       2'h1
`define EPIS_IDX_FLAGS      2'h2
`define EPIS_IDX_IRQ_STAT   2'h3

// field positions
`define EPIS_SENSE_A_LSB    0
`define EPIS_SENSE_B_LSB    2
`define EPIS_LINE_A_BIT     0
`define EPIS_LINE_B_BIT     1
`define EPIS_IRQ_EN_LSB     8

// reset values
`define EPIS_SENSE_RST      4'h0
`define EPIS_MASK_RST       2'h0
`define EPIS_FLAGS_RST      2'h0
// pins idle high; synchroniser reset level avoids a false edge
`define EPIS_PIN_IDLE       '1

// answer to an unmapped read
`define EPIS_UNMAPPED_RD    32'h0000_0000

`endif

// ### hdl/epis_pkg.sv
// types shared by the pin interrupt block
package epis_pkg;

	// sense field encoding, one per line
	typedef enum logic [1:0]
	{
		EPIS_SENSE_LOW  = 2'h0,
		EPIS_SENSE_ANY  = 2'h1,
		EPIS_SENSE_FALL = 2'h2,
		EPIS_SENSE_RISE = 2'h3
	} epis_sense_e;

	// bus slave answer sequence, gray from idle to done; the step back to idle changes two bits
	typedef enum logic [1:0]
	{
		EPIS_BUS_IDLE = 2'h0,
		EPIS_BUS_ACK  = 2'h1,
		EPIS_BUS_DONE = 2'h3
	} epis_bus_e;

endpackage

// ### tb/epis_pin_model.sv
// board-side driver of the two interrupt pins
`timescale 1ns/1ps
`default_nettype none
module epis_pin_model
(
	// clock and wanted levels
	input  wire logic       clk_in,
	input  wire logic [1:0] level_in,
	// pins to the block
	output logic      [1:0] pin_out
);
	// idle high; each level is held for several clocks
	initial pin_out = 2'h3;
	always @(posedge clk_in)
		pin_out <= level_in;
endmodule
`default_nettype wire

// ### tb/epis_ext_irq_sva.sv
// port assertions for the pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module epis_ext_irq_sva
#(
	parameter int NUM_LINES = 2
)
(
	// watched ports
	input wire logic                 core_clk_in,
	input wire logic                 srst_in,
	input wire logic                 avs_read_in,
	input wire logic                 avs_write_in,
	input wire logic [31:0]          avs_readdata_out,
	input wire logic                 avs_waitrequest_out,
	input wire logic [NUM_LINES-1:0] ext_irq_pin_in,
	input wire logic                 global_irq_enable_in,
	input wire logic [NUM_LINES-1:0] vector_req_out,
	input wire logic                 wake_req_out,
	input wire logic                 irq_out
);
	// request pending, then the two answer steps
	wire logic rq = avs_read_in | avs_write_in;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	sequence s_ask; rq && avs_waitrequest_out; endsequence
	sequence s_take; rq && !avs_waitrequest_out; endsequence
	a_one_wait: assert property (s_ask |=> s_take)
		else $error("no answer after one wait");
	a_done_gap: assert property (s_take |=> !rq || avs_waitrequest_out)
		else $error("next request not held off");
	a_rdata_hold: assert property (!avs_read_in |=> $stable(avs_readdata_out))
		else $error("read data moved");
	a_gate_line_a: assert property (vector_req_out[0] |-> global_irq_enable_in)
		else $error("line a request ungated");
	a_gate_line_b: assert property (vector_req_out[1] |-> global_irq_enable_in)
		else $error("line b request ungated");
	a_wake_pin: assert property (wake_req_out |-> !(&ext_irq_pin_in))
		else $error("wake without low pin");
	a_reset_quiet: assert property (disable iff (1'b0)
		srst_in |=> vector_req_out == '0 && !irq_out) else $error("reset busy");
	a_reset_rdata: assert property (disable iff (1'b0)
		srst_in |=> avs_readdata_out == '0) else $error("reset data");
endmodule
`default_nettype wire

// ### tb/epis_ext_irq_tb.sv
// self-checking bench for the pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module epis_ext_irq_tb;
	// bench signals
	logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, ge = 1'b0;
	logic waitreq, wake, irq;
	logic [3:0] adr = 4'h0;
	logic [1:0] lvl = 2'h3, ack = 2'h0, pin, req;
	logic [31:0] wd = 32'h0, rdo, rdat;
	int n_fail = 0, checks_done = 0, cyc = 0;
	// design and pin driver
	epis_ext_irq u_epis_ext_irq (.core_clk_in(clk), .srst_in(srst),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_byteenable_in(4'hF),
		.avs_readdata_out(rdo), .avs_waitrequest_out(waitreq),
		.ext_irq_pin_in(pin), .global_irq_enable_in(ge),
		.vector_req_out(req), .vector_ack_in(ack),
		.wake_req_out(wake), .irq_out(irq));
	epis_pin_model u_epis_pin_model (.clk_in(clk), .level_in(lvl),
		.pin_out(pin));
	// clock and hang guard
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	// one avalon transfer, held until waitrequest drops
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= d;
		@(posedge clk);
		while (waitreq !== 1'b0)
			@(posedge clk);
		rdat = rdo;
		rd <= 1'b0;
		wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e, string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	task automatic pins(input logic [1:0] v);
		@(posedge clk);
		lvl <= v;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic report_and_stop();
		if (n_fail == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// register map, sense codes, gating, flags, level mode, interrupt
	initial
	begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++)
			rchk(4'(4 * i), 32'h0, "reset");
		bus(1'b1, 4'h0, 32'hFF);
		rchk(4'h0, 32'hF, "sense");
		bus(1'b1, 4'h4, 32'hFF);
		rchk(4'h4, 32'h3, "mask");
		bus(1'b1, 4'h4, 32'h0);
		for (int l = 0; l < 2; l++)
			for (int m = 1; m < 4; m++)
			begin
				bus(1'b1, 4'h0, 32'(m << (2 * l)));
				bus(1'b1, 4'h8, 32'h3);
				pins(~(2'h1 << l));
				rchk(4'h8, 32'(m < 3) << l, "fall");
				bus(1'b1, 4'h8, 32'h3);
				pins(2'h3);
				rchk(4'h8, 32'(m != 2) << l, "rise");
			end
		bus(1'b1, 4'h0, 32'hF);
		bus(1'b1, 4'h4, 32'h3);
		pins(2'h0);
		pins(2'h3);
		chk("gated", 32'h0, req);
		@(posedge clk);
		ge <= 1'b1;
		@(negedge clk);
		chk("req", 32'h3, req);
		bus(1'b1, 4'h8, 32'h0);
		rchk(4'h8, 32'h3, "keep");
		@(posedge clk);
		ack <= 2'h1;
		@(posedge clk);
		ack <= 2'h0;
		rchk(4'h8, 32'h2, "ack");
		bus(1'b1, 4'h8, 32'h2);
		rchk(4'h8, 32'h0, "clear");
		bus(1'b1, 4'hC, 32'h3);
		bus(1'b1, 4'h0, 32'h0);
		pins(2'h2);
		chk("wake", 32'h1, wake);
		chk("level", 32'h1, req);
		rchk(4'h8, 32'h0, "lvlflag");
		bus(1'b1, 4'hC, 32'h100);
		chk("irq", 32'h1, irq);
		bus(1'b1, 4'hC, 32'h0);
		chk("irqmask", 32'h0, irq);
		pins(2'h3);
		bus(1'b1, 4'hC, 32'h101);
		rchk(4'hC, 32'h100, "stat");
		chk("irqclr", 32'h0, irq);
		report_and_stop();
	end
endmodule
bind epis_ext_irq epis_ext_irq_sva #(.NUM_LINES(NUM_LINES)) u_epis_ext_irq_sva (.*);
`default_nettype wire
